// ==== src/facq_pkg.sv ====
// package: register map, field layout, modes and timing of frame acquisition
package facq_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF      = 8'h00;
    localparam logic [7:0] CMD_OFF       = 8'h04;
    localparam logic [7:0] COUNT_OFF     = 8'h08;
    localparam logic [7:0] HEIGHT_OFF    = 8'h0c;
    localparam logic [7:0] TIMEOUT_OFF   = 8'h10;
    localparam logic [7:0] SEL_OFF       = 8'h14;
    localparam logic [7:0] STATUS_OFF    = 8'h18;
    localparam logic [7:0] LINES_OFF     = 8'h1c;
    localparam logic [7:0] XFER_OFF      = 8'h20;
    localparam logic [7:0] ADDR_MASK     = 8'hfc;
    // control fields
    localparam int MODE_LSB      = 0;
    localparam int HALT_LSB      = 2;
    localparam int TRIG_EN_BIT   = 4;
    // command bits
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT  = 1;
    localparam int CMD_ARM_BIT   = 2;
    // status fields
    localparam int ST_VALUE_BIT  = 0;
    localparam int ST_ARMED_BIT  = 1;
    localparam int ST_STATE_LSB  = 4;
    // widths
    localparam int LINE_W        = 16;
    localparam int FRAME_W       = 16;
    localparam int TOUT_W        = 24;
    localparam int INLINES_W     = 8;
    localparam int PIX_W         = 16;
    localparam int ARM_CYCLES_W  = 4;
    // reset values
    localparam logic [15:0] HEIGHT_RST  = 16'h0400;
    localparam logic [15:0] COUNT_RST   = 16'h0001;
    localparam logic [23:0] TIMEOUT_RST = 24'h00ffff;
    localparam logic [15:0] PAD_PIXEL   = 16'h0000;
    // arm step duration
    localparam int  ARM_TIME_NS  = 40;
    localparam int  CLK_NS       = 5;
    localparam logic [3:0] ARM_CYCLES =
        4'((ARM_TIME_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {
        FACQ_ONE_SHOT_CAPTURE = 2'b00,
        FACQ_COUNTED_CAPTURE  = 2'b01,
        FACQ_CONTINUOUS       = 2'b10
    } facq_mode_t;

    typedef enum logic [1:0] {
        FACQ_COMPLETE                  = 2'b00,
        FACQ_CUT_AND_FILL              = 2'b01,
        FACQ_FINISH_OR_FILL_ON_TIMEOUT = 2'b10
    } facq_halt_t;

    typedef enum logic [2:0] {
        FACQ_IDLE   = 3'b000,
        FACQ_ARMING = 3'b001,
        FACQ_WAIT   = 3'b010,
        FACQ_LINE   = 3'b011,
        FACQ_PAD    = 3'b100
    } facq_state_t;
endpackage : facq_pkg

// ==== src/facq_ctrl.sv ====
// file: frame acquisition controller with apb register slave
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps

module facq_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        line_trigger,
    input  wire logic [7:0]  input_lines,
    output logic             trigger_wait_flag,
    output logic             capture_active_flag,
    output logic             line_valid,
    output logic             line_is_pad,
    output logic             frame_start,
    output logic             frame_end,
    output logic      [15:0] pad_pixel,
    output logic      [7:0]  input_lines_snapshot
);
    // =========================================================
    // input synchronisers
    logic [2:0] trig_sync_reg;
    logic [7:0] lines_s1_reg;
    logic [7:0] lines_s2_reg;
    logic [7:0] lines_s3_reg;
    logic       trig_stable_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_sync_reg   <= 3'h0;
            lines_s1_reg    <= 8'h00;
            lines_s2_reg    <= 8'h00;
            lines_s3_reg    <= 8'h00;
            trig_stable_reg <= 1'b0;
        end else begin
            trig_sync_reg <= {trig_sync_reg[1:0], line_trigger};
            lines_s1_reg  <= input_lines;
            lines_s2_reg  <= lines_s1_reg;
            lines_s3_reg  <= lines_s2_reg;
            if (trig_sync_reg[1] == trig_sync_reg[2])
                trig_stable_reg <= trig_sync_reg[2];
        end
    end

    wire trig_agree = trig_sync_reg[1] == trig_sync_reg[2];
    wire trig_rise  = trig_agree && trig_sync_reg[2] && !trig_stable_reg;
    wire lines_agree = lines_s2_reg == lines_s3_reg;

    // =========================================================
    // apb decode
    logic [31:0] ctrl_reg;
    logic [15:0] count_reg;
    logic [15:0] height_reg;
    logic [23:0] timeout_reg;
    logic        sel_reg;
    logic [31:0] xfer_reg;
    logic        armed_reg;
    facq_pkg::facq_state_t state_reg;

    wire        acc      = psel && penable;
    wire [7:0]  word     = paddr & facq_pkg::ADDR_MASK;
    wire        wr       = acc && pwrite;
    wire        hit_ctrl = word == facq_pkg::CTRL_OFF;
    wire        hit_cmd  = word == facq_pkg::CMD_OFF;
    wire        hit_cnt  = word == facq_pkg::COUNT_OFF;
    wire        hit_ht   = word == facq_pkg::HEIGHT_OFF;
    wire        hit_to   = word == facq_pkg::TIMEOUT_OFF;
    wire        hit_sel  = word == facq_pkg::SEL_OFF;
    wire        hit_st   = word == facq_pkg::STATUS_OFF;
    wire        hit_ln   = word == facq_pkg::LINES_OFF;
    wire        hit_xf   = word == facq_pkg::XFER_OFF;
    wire        mapped   = hit_ctrl | hit_cmd | hit_cnt | hit_ht | hit_to
                         | hit_sel | hit_st | hit_ln | hit_xf;
    wire        cmd_start = wr && hit_cmd && pwdata[facq_pkg::CMD_START_BIT];
    wire        cmd_stop  = wr && hit_cmd && pwdata[facq_pkg::CMD_STOP_BIT];
    wire        cmd_arm   = wr && hit_cmd && pwdata[facq_pkg::CMD_ARM_BIT];
    // transfer-related settings force a new arm step
    wire        xfer_change = wr && (hit_xf || hit_ht);

    facq_pkg::facq_mode_t cur_mode;
    facq_pkg::facq_halt_t cur_halt;
    assign cur_mode =
        facq_pkg::facq_mode_t'(ctrl_reg[facq_pkg::MODE_LSB +: 2]);
    assign cur_halt =
        facq_pkg::facq_halt_t'(ctrl_reg[facq_pkg::HALT_LSB +: 2]);
    wire trig_en = ctrl_reg[facq_pkg::TRIG_EN_BIT];

    wire status_value = sel_reg ? capture_active_flag
                                : trigger_wait_flag;
    wire [31:0] status_word = {25'h0, state_reg, 2'h0, armed_reg,
                               status_value};
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl_reg :
        hit_cnt  ? {16'h0, count_reg} :
        hit_ht   ? {16'h0, height_reg} :
        hit_to   ? {8'h0, timeout_reg} :
        hit_sel  ? {31'h0, sel_reg} :
        hit_st   ? status_word :
        hit_ln   ? {24'h0, input_lines_snapshot} :
        hit_xf   ? xfer_reg : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= 32'h0;
            count_reg   <= facq_pkg::COUNT_RST;
            height_reg  <= facq_pkg::HEIGHT_RST;
            timeout_reg <= facq_pkg::TIMEOUT_RST;
            sel_reg     <= 1'b0;
            xfer_reg    <= 32'h0;
            prdata      <= 32'h0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite)
                prdata <= rd_mux;
            if (wr && hit_ctrl)
                ctrl_reg <= {27'h0, pwdata[4:0]};
            if (wr && hit_cnt)
                count_reg <= pwdata[15:0];
            if (wr && hit_ht)
                height_reg <= pwdata[15:0];
            if (wr && hit_to)
                timeout_reg <= pwdata[23:0];
            if (wr && hit_sel)
                sel_reg <= pwdata[0];
            if (wr && hit_xf)
                xfer_reg <= pwdata;
        end
    end

    // =========================================================
    // acquisition state machine
    facq_pkg::facq_state_t state_next;
    logic [15:0] line_cnt_reg;
    logic [15:0] frame_cnt_reg;
    logic [23:0] tout_cnt_reg;
    logic [3:0]  arm_cnt_reg;
    logic        stop_req_reg;
    logic        start_after_arm_reg;

    wire settings_ok  = height_reg != 16'h0 &&
                        (cur_mode != facq_pkg::FACQ_COUNTED_CAPTURE ||
                         count_reg != 16'h0) &&
                        cur_mode != 2'b11 && cur_halt != 2'b11;
    wire in_frame     = state_reg == facq_pkg::FACQ_LINE;
    wire line_go      = in_frame && (!trig_en || trig_rise);
    wire last_line    = line_cnt_reg == height_reg - 16'h1;
    wire timed_out    = trig_en && in_frame &&
                        tout_cnt_reg >= timeout_reg;
    wire stop_now     = stop_req_reg || cmd_stop;
    wire cut          = in_frame && stop_now && !(line_go && last_line) &&
                        cur_halt == facq_pkg::FACQ_CUT_AND_FILL;
    wire fill_tout    = in_frame && stop_now && timed_out && !line_go &&
        cur_halt == facq_pkg::FACQ_FINISH_OR_FILL_ON_TIMEOUT;
    wire frames_done  =
        cur_mode == facq_pkg::FACQ_ONE_SHOT_CAPTURE ||
        (cur_mode == facq_pkg::FACQ_COUNTED_CAPTURE &&
         frame_cnt_reg == count_reg - 16'h1) ||
        stop_now;
    wire pad_last     = state_reg == facq_pkg::FACQ_PAD && last_line;
    wire frame_done   = (line_go && last_line) || pad_last;
    wire begin_ok     = cmd_start && settings_ok;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            facq_pkg::FACQ_IDLE: begin
                if (begin_ok && !armed_reg)
                    state_next = facq_pkg::FACQ_ARMING;
                else if (begin_ok)
                    state_next = facq_pkg::FACQ_WAIT;
                else if (cmd_arm && settings_ok)
                    state_next = facq_pkg::FACQ_ARMING;
            end
            facq_pkg::FACQ_ARMING: begin
                if (arm_cnt_reg == facq_pkg::ARM_CYCLES)
                    state_next = start_after_arm_reg ?
                        facq_pkg::FACQ_WAIT : facq_pkg::FACQ_IDLE;
            end
            facq_pkg::FACQ_WAIT: begin
                if (stop_now)
                    state_next = facq_pkg::FACQ_IDLE;
                else if (!trig_en || trig_rise)
                    state_next = facq_pkg::FACQ_LINE;
            end
            facq_pkg::FACQ_LINE: begin
                if (cut || fill_tout)
                    state_next = facq_pkg::FACQ_PAD;
                else if (line_go && last_line)
                    state_next = frames_done ? facq_pkg::FACQ_IDLE
                                             : facq_pkg::FACQ_LINE;
            end
            facq_pkg::FACQ_PAD: begin
                if (last_line)
                    state_next = facq_pkg::FACQ_IDLE;
            end
            default: state_next = facq_pkg::FACQ_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg            <= facq_pkg::FACQ_IDLE;
            line_cnt_reg         <= 16'h0;
            frame_cnt_reg        <= 16'h0;
            tout_cnt_reg         <= 24'h0;
            arm_cnt_reg          <= 4'h0;
            armed_reg            <= 1'b0;
            stop_req_reg         <= 1'b0;
            start_after_arm_reg  <= 1'b0;
            trigger_wait_flag    <= 1'b0;
            capture_active_flag  <= 1'b0;
            line_valid           <= 1'b0;
            line_is_pad          <= 1'b0;
            frame_start          <= 1'b0;
            frame_end            <= 1'b0;
            pad_pixel            <= 16'h0;
            input_lines_snapshot <= 8'h00;
        end else begin
            state_reg <= state_next;
            arm_cnt_reg <= state_reg == facq_pkg::FACQ_ARMING ?
                           arm_cnt_reg + 4'h1 : 4'h0;
            if (state_reg == facq_pkg::FACQ_IDLE)
                start_after_arm_reg <= begin_ok;
            if (xfer_change)
                armed_reg <= 1'b0;
            else if (state_reg == facq_pkg::FACQ_ARMING &&
                     arm_cnt_reg == facq_pkg::ARM_CYCLES)
                armed_reg <= 1'b1;
            if (state_next == facq_pkg::FACQ_IDLE)
                stop_req_reg <= 1'b0;
            else if (cmd_stop && state_reg != facq_pkg::FACQ_IDLE)
                stop_req_reg <= 1'b1;
            tout_cnt_reg <= (line_go || !in_frame) ? 24'h0
                          : tout_cnt_reg + 24'h1;
            if (state_reg == facq_pkg::FACQ_WAIT)
                frame_cnt_reg <= 16'h0;
            else if (frame_done)
                frame_cnt_reg <= frame_cnt_reg + 16'h1;
            if (state_reg == facq_pkg::FACQ_WAIT || frame_done)
                line_cnt_reg <= 16'h0;
            else if (line_go || state_reg == facq_pkg::FACQ_PAD)
                line_cnt_reg <= line_cnt_reg + 16'h1;
            trigger_wait_flag   <= state_next == facq_pkg::FACQ_WAIT;
            capture_active_flag <= state_next == facq_pkg::FACQ_LINE ||
                                   state_next == facq_pkg::FACQ_PAD;
            line_valid  <= line_go || state_reg == facq_pkg::FACQ_PAD;
            line_is_pad <= state_reg == facq_pkg::FACQ_PAD;
            pad_pixel   <= facq_pkg::PAD_PIXEL;
            frame_start <= (line_go || state_reg == facq_pkg::FACQ_PAD) &&
                           line_cnt_reg == 16'h0;
            frame_end   <= frame_done;
            if (line_go && line_cnt_reg == 16'h0 && lines_agree)
                input_lines_snapshot <= lines_s3_reg;
        end
    end

    // =========================================================
    // assertions
    a_wait_flag_state: assert property (@(posedge pclk) disable iff (!presetn)
        trigger_wait_flag == (state_reg == facq_pkg::FACQ_WAIT))
        else $error("trigger wait flag mismatches state");
    a_active_flag_state: assert property (@(posedge pclk)
        disable iff (!presetn)
        capture_active_flag == (state_reg == facq_pkg::FACQ_LINE ||
                                state_reg == facq_pkg::FACQ_PAD))
        else $error("active flag mismatches state");
    a_one_shot_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_done && cur_mode == facq_pkg::FACQ_ONE_SHOT_CAPTURE)
        |=> state_reg == facq_pkg::FACQ_IDLE)
        else $error("one shot did not stop");
    a_cont_keeps_going: assert property (@(posedge pclk)
        disable iff (!presetn)
        (line_go && last_line && !stop_now &&
         cur_mode == facq_pkg::FACQ_CONTINUOUS)
        |=> state_reg == facq_pkg::FACQ_LINE)
        else $error("continuous mode stopped without command");
    a_cut_goes_pad: assert property (@(posedge pclk) disable iff (!presetn)
        cut |=> state_reg == facq_pkg::FACQ_PAD)
        else $error("cut and fill did not pad");
    a_complete_no_pad: assert property (@(posedge pclk)
        disable iff (!presetn)
        (in_frame && cur_halt == facq_pkg::FACQ_COMPLETE)
        |=> state_reg != facq_pkg::FACQ_PAD)
        else $error("complete mode padded");
    a_pad_marked: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == facq_pkg::FACQ_PAD |=> line_valid && line_is_pad)
        else $error("pad line not emitted");
    a_armed_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == facq_pkg::FACQ_IDLE && begin_ok && armed_reg)
        |=> state_reg == facq_pkg::FACQ_WAIT)
        else $error("armed start did not skip arm step");
endmodule : facq_ctrl

// ==== verif/facq_trig_src.sv ====
// partner model: line trigger source standing in for the external encoder
`timescale 1ns/100ps

module facq_trig_src #(
    parameter int PERIOD = 16
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic en,
    output logic      line_trigger
);
    // ========================================================
    // pulse generator
    int cnt;

    // high for four cycles so the three-stage sync sees every edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt          <= 0;
            line_trigger <= 1'b0;
        end else if (en) begin
            cnt          <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            line_trigger <= (cnt < 4);
        end else begin
            cnt          <= 0;
            line_trigger <= 1'b0;
        end
    end
endmodule : facq_trig_src

// ==== verif/tb.sv ====
// testbench: apb driven acquisition scenarios with line stream monitor
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module tb;
    // ========================================================
    // signals
    logic        pclk, presetn, psel, penable, pwrite, err, trig_en;
    logic [7:0]  paddr, input_lines, snap;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, line_trigger, twf, caf, lv, lp, fs, fe;
    logic [15:0] pad_pixel, lc, exp_h, frames, lines, pads;
    int          n_errors, checks, cyc;

    facq_ctrl i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_trigger(line_trigger),
        .input_lines(input_lines), .trigger_wait_flag(twf),
        .capture_active_flag(caf), .line_valid(lv), .line_is_pad(lp),
        .frame_start(fs), .frame_end(fe), .pad_pixel(pad_pixel),
        .input_lines_snapshot(snap)
    );

    facq_trig_src #(.PERIOD(16)) i_trig (
        .pclk(pclk), .presetn(presetn), .en(trig_en),
        .line_trigger(line_trigger)
    );

    // ========================================================
    // clock, timeout and line monitor
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            tally_and_finish();
        end else if (presetn) begin
            `CHK(fs, lv && lc == 16'h0)
            if (lv) begin
                lc++;
                lines++;
                if (lp) pads++;
            end
            if (fe) begin
                `CHK(lc, exp_h)
                lc = 16'h0000;
                frames++;
            end
        end
    end

    // ========================================================
    // tasks
    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cmd(input int b);
        apb(1'b1, facq_pkg::CMD_OFF, 32'h1 << b);
    endtask : cmd

    task automatic status(input logic [31:0] sel);
        apb(1'b1, facq_pkg::SEL_OFF, sel);
        apb(1'b0, facq_pkg::STATUS_OFF, 32'h0);
    endtask : status

    task automatic wait_idle();
        int i;
        repeat (2) @(posedge pclk);
        for (i = 0; i < 600; i++) begin
            apb(1'b0, facq_pkg::STATUS_OFF, 32'h0);
            if (rd[facq_pkg::ST_STATE_LSB +: 3] === facq_pkg::FACQ_IDLE)
                break;
        end
        `CHK(i < 600, 1'b1)
    endtask : wait_idle

    task automatic wait_lc(input logic [15:0] n);
        int i;
        for (i = 0; i < 2000 && lc !== n; i++) @(posedge pclk);
    endtask : wait_lc

    task automatic clr();
        frames = 16'h0000;
        lines  = 16'h0000;
        pads   = 16'h0000;
    endtask : clr

    // ========================================================
    // main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; input_lines = 8'h00;
        trig_en = 1'b0; lc = 16'h0000; exp_h = 16'h0004; clr();
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, facq_pkg::HEIGHT_OFF, 32'h0);
        `CHK(rd, {16'h0000, facq_pkg::HEIGHT_RST})
        apb(1'b0, facq_pkg::COUNT_OFF, 32'h0);
        `CHK(rd, {16'h0000, facq_pkg::COUNT_RST})
        apb(1'b0, facq_pkg::TIMEOUT_OFF, 32'h0);
        `CHK(rd, {8'h00, facq_pkg::TIMEOUT_RST})
        apb(1'b0, 8'h40, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        // one shot, free running
        apb(1'b1, facq_pkg::HEIGHT_OFF, 32'h4);
        apb(1'b1, facq_pkg::CTRL_OFF, 32'h00);
        input_lines <= 8'h5a;
        cmd(facq_pkg::CMD_START_BIT);
        wait_idle();
        `CHK({frames, lines, pads}, {16'h1, 16'h4, 16'h0})
        `CHK(rd[facq_pkg::ST_ARMED_BIT], 1'b1)
        apb(1'b0, facq_pkg::LINES_OFF, 32'h0);
        `CHK({snap, rd}, {8'h5a, 32'h5a})
        // counted capture of three frames
        clr();
        apb(1'b1, facq_pkg::COUNT_OFF, 32'h3);
        apb(1'b1, facq_pkg::CTRL_OFF, 32'h01);
        cmd(facq_pkg::CMD_START_BIT);
        wait_idle();
        `CHK({frames, lines}, {16'h3, 16'hc})
        `CHK(rd[facq_pkg::ST_ARMED_BIT], 1'b1)
        apb(1'b1, facq_pkg::XFER_OFF, 32'h1);
        apb(1'b0, facq_pkg::STATUS_OFF, 32'h0);
        `CHK(rd[facq_pkg::ST_ARMED_BIT], 1'b0)
        cmd(facq_pkg::CMD_ARM_BIT);
        repeat (12) @(posedge pclk);
        apb(1'b0, facq_pkg::STATUS_OFF, 32'h0);
        `CHK(rd[facq_pkg::ST_ARMED_BIT], 1'b1)
        // continuous, triggered, complete on stop
        clr();
        apb(1'b1, facq_pkg::CTRL_OFF, 32'h12);
        cmd(facq_pkg::CMD_START_BIT);
        repeat (20) @(posedge pclk);
        `CHK(twf, 1'b1)
        status(32'h0);
        `CHK(rd[facq_pkg::ST_VALUE_BIT], 1'b1)
        trig_en <= 1'b1;
        wait_lc(16'h1);
        status(32'h1);
        `CHK(rd[facq_pkg::ST_VALUE_BIT], 1'b1)
        `CHK(caf, 1'b1)
        repeat (150) @(posedge pclk);
        cmd(facq_pkg::CMD_STOP_BIT);
        wait_idle();
        `CHK({pads, frames > 16'h2}, {16'h0, 1'b1})
        status(32'h1);
        `CHK(rd[facq_pkg::ST_VALUE_BIT], 1'b0)
        `CHK(caf, 1'b0)
        // continuous, cut and fill on stop
        clr();
        apb(1'b1, facq_pkg::CTRL_OFF, 32'h16);
        cmd(facq_pkg::CMD_START_BIT);
        wait_lc(16'h1);
        cmd(facq_pkg::CMD_STOP_BIT);
        wait_idle();
        `CHK(pads != 16'h0, 1'b1)
        `CHK(pad_pixel, facq_pkg::PAD_PIXEL)
        // finish or fill after trigger timeout
        clr();
        apb(1'b1, facq_pkg::TIMEOUT_OFF, 32'h14);
        apb(1'b1, facq_pkg::CTRL_OFF, 32'h1a);
        cmd(facq_pkg::CMD_START_BIT);
        wait_lc(16'h1);
        trig_en <= 1'b0;
        cmd(facq_pkg::CMD_STOP_BIT);
        wait_idle();
        `CHK(pads != 16'h0, 1'b1)
        tally_and_finish();
    end
endmodule : tb
